/* hdl/gyrcf_pkg.sv */
package gyrcf_pkg;

   // -------------------------------------------------------------------
   // Register offsets.
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_ZB_HI   = 8'h17;
   localparam logic [7:0] ADDR_ZB_LO   = 8'h18;
   localparam logic [7:0] ADDR_DIV     = 8'h19;
   localparam logic [7:0] ADDR_GCFG    = 8'h1a;
   localparam logic [7:0] ADDR_RCFG    = 8'h1b;
   localparam logic [7:0] ADDR_TEMP_HI = 8'h41;
   localparam logic [7:0] ADDR_TEMP_LO = 8'h42;
   localparam logic [7:0] ADDR_X_HI    = 8'h43;
   localparam logic [7:0] ADDR_X_LO    = 8'h44;
   localparam logic [7:0] ADDR_Y_HI    = 8'h45;
   localparam logic [7:0] ADDR_Y_LO    = 8'h46;
   localparam logic [7:0] ADDR_Z_HI    = 8'h47;
   localparam logic [7:0] ADDR_Z_LO    = 8'h48;
   localparam logic [7:0] ADDR_FCOUNT  = 8'h72;
   localparam logic [7:0] ADDR_FDATA_H = 8'h73;
   localparam logic [7:0] ADDR_FDATA_L = 8'h74;

   // -------------------------------------------------------------------
   // Reset values, write masks and field positions.
   // -------------------------------------------------------------------
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [7:0] GCFG_WMASK = 8'h7f;
   localparam logic [7:0] RCFG_WMASK = 8'hfb;
   localparam int FIFO_MODE_BIT = 6;
   localparam int SYNC_SEL_LSB  = 3;
   localparam int LP_LSB        = 0;
   localparam int FS_LSB        = 3;
   localparam int BYP_LSB       = 0;
   localparam int ST_LSB        = 5;

   // Sync select codes and the wide lowpass setting.
   localparam logic [2:0] SYNC_TEMP = 3'h1;
   localparam logic [2:0] SYNC_X    = 3'h2;
   localparam logic [2:0] SYNC_Y    = 3'h3;
   localparam logic [2:0] SYNC_Z    = 3'h4;
   localparam logic [2:0] LP_WIDE   = 3'h7;

   // -------------------------------------------------------------------
   // Timing.
   // -------------------------------------------------------------------
   localparam int CLK_HZ      = 100_000_000;
   localparam int RATE_1K_HZ  = 1000;
   localparam int RATE_8K_HZ  = 8000;
   localparam int RATE_32K_HZ = 32000;
   localparam int CYC_1K_DEF  = CLK_HZ / RATE_1K_HZ;
   localparam int CYC_8K_DEF  = CLK_HZ / RATE_8K_HZ;
   localparam int CYC_32K     = CLK_HZ / RATE_32K_HZ;

   // -------------------------------------------------------------------
   // Bandwidth and range tables, indexed by lowpass setting or range.
   // -------------------------------------------------------------------
   localparam logic [13:0] RATE_BW_HZ [8] = '{14'h00fa, 14'h00b0,
      14'h005c, 14'h0029, 14'h0014, 14'h000a, 14'h0005, 14'h0cd1};
   localparam logic [11:0] TEMP_BW_HZ [8] = '{12'hfa0, 12'h0bc,
      12'h062, 12'h02a, 12'h014, 12'h00a, 12'h005, 12'hfa0};
   localparam logic [13:0] RATE_BW_BYP0 = 14'h1fed;
   localparam logic [13:0] RATE_BW_BYP1 = 14'h0cd1;
   localparam logic [11:0] TEMP_BW_BYP  = 12'hfa0;
   localparam logic [10:0] FS_DPS [4] = '{11'h0fa, 11'h1f4,
      11'h3e8, 11'h7d0};
   localparam logic [5:0] KHZ_32 = 6'h20;
   localparam logic [5:0] KHZ_8  = 6'h08;
   localparam logic [5:0] KHZ_1  = 6'h01;

   // FIFO geometry.
   localparam int FIFO_AW = 4;
   localparam int FIFO_W  = 16;

endpackage

/* hdl/gyrcf_sync2.sv */
`timescale 1ns/1ns
module gyrcf_sync2
(
   input  wire logic clk_i,  // System clock.
   input  wire logic rstn_i, // Asynchronous reset, active low.
   input  wire logic d_i,    // Asynchronous input.
   output logic      q_o     // Synchronised level.
);

   logic meta;

   // Two flops; only the second one reads the first.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

/* hdl/gyrcf_fifo_mem.sv */
`timescale 1ns/1ns
module gyrcf_fifo_mem
#(
   parameter int W  = 16,
   parameter int AW = 4
)
(
   input  wire logic          clk_i,   // System clock.
   input  wire logic          we_i,    // Write enable.
   input  wire logic [AW-1:0] waddr_i, // Write address.
   input  wire logic [W-1:0]  wdata_i, // Write data.
   input  wire logic [AW-1:0] raddr_i, // Read address.
   output logic      [W-1:0]  rdata_o  // Registered read data.
);

   logic [W-1:0] mem [2**AW];

   // Read data come from a register so the array maps onto block memory.
   always_ff @(posedge clk_i)
   begin
      if (we_i)
         mem[waddr_i] <= wdata_i;
      rdata_o <= mem[raddr_i];
   end

endmodule

/* hdl/gyrcf_top.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ns
module gyrcf_top
#(
   parameter int CYC_1K = gyrcf_pkg::CYC_1K_DEF,
   parameter int CYC_8K = gyrcf_pkg::CYC_8K_DEF
)
(
   input  wire logic        clk_i,        // System clock, 100 MHz.
   input  wire logic        rstn_i,       // Async reset, active low.
   input  wire logic [7:0]  addr_i,       // Register address.
   input  wire logic [7:0]  wdata_i,      // Write data.
   input  wire logic        wr_i,         // Write strobe.
   input  wire logic        rd_i,         // Read strobe.
   output logic      [7:0]  rdata_o,      // Read data, cycle after rd_i.
   input  wire logic [15:0] raw_temp_i,   // Raw temperature sample.
   input  wire logic [15:0] raw_x_i,      // Raw X rate sample.
   input  wire logic [15:0] raw_y_i,      // Raw Y rate sample.
   input  wire logic [15:0] raw_z_i,      // Raw Z rate sample.
   input  wire logic        frame_sync_i, // External frame sync pin.
   output logic             sample_o,     // Output sample strobe.
   output logic      [5:0]  rate_khz_o,   // Internal rate in kHz.
   output logic      [13:0] rate_bw_o,    // Rate 3 dB bandwidth, Hz.
   output logic      [11:0] temp_bw_o,    // Temp 3 dB bandwidth, Hz.
   output logic      [10:0] fs_dps_o,     // Full scale, deg per s.
   output logic      [1:0]  full_scale_select_o,     // Full scale select code.
   output logic      [2:0]  self_test_o,  // Self-test X, Y, Z.
   output logic             fifo_full_o   // FIFO is full.
);

   // -------------------------------------------------------------------
   // Configuration registers.
   // -------------------------------------------------------------------
   logic [15:0] z_bias;
   logic [7:0]  div;
   logic [7:0]  gcfg;
   logic [7:0]  rcfg;

   // Reserved bits are masked on write so they always read back as zero.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         z_bias <= {gyrcf_pkg::REG_RESET, gyrcf_pkg::REG_RESET};
         div    <= gyrcf_pkg::REG_RESET;
         gcfg   <= gyrcf_pkg::REG_RESET;
         rcfg   <= gyrcf_pkg::REG_RESET;
      end
      else if (wr_i)
      begin
         unique case (addr_i)
            gyrcf_pkg::ADDR_ZB_HI: z_bias[15:8] <= wdata_i;
            gyrcf_pkg::ADDR_ZB_LO: z_bias[7:0]  <= wdata_i;
            gyrcf_pkg::ADDR_DIV:   div <= wdata_i;
            gyrcf_pkg::ADDR_GCFG:  gcfg <= wdata_i & gyrcf_pkg::GCFG_WMASK;
            gyrcf_pkg::ADDR_RCFG:  rcfg <= wdata_i & gyrcf_pkg::RCFG_WMASK;
            default: ;
         endcase
      end
   end

   logic [1:0] bypass;
   logic [2:0] lp;
   logic [2:0] sync_sel;
   logic [1:0] fs;
   logic       fifo_mode;
   assign bypass    = rcfg[gyrcf_pkg::BYP_LSB +: 2];
   assign fs        = rcfg[gyrcf_pkg::FS_LSB +: 2];
   assign lp        = gcfg[gyrcf_pkg::LP_LSB +: 3];
   assign sync_sel  = gcfg[gyrcf_pkg::SYNC_SEL_LSB +: 3];
   assign fifo_mode = gcfg[gyrcf_pkg::FIFO_MODE_BIT];

   // -------------------------------------------------------------------
   // Internal rate tick.
   // -------------------------------------------------------------------
   logic [16:0] period;
   logic [16:0] tick_cnt;
   logic        tick;
   logic        lp_fast;

   // Settings 0 and 7 run the filter at 8 kHz, the rest at 1 kHz.
   assign lp_fast = (lp == 3'h0) || (lp == gyrcf_pkg::LP_WIDE);

   always_comb
   begin
      if (bypass != 2'b00)
         period = 17'(gyrcf_pkg::CYC_32K - 1);
      else if (lp_fast)
         period = 17'(CYC_8K - 1);
      else
         period = 17'(CYC_1K - 1);
   end

   // A shorter period after a rate change ends the current interval now.
   assign tick = (tick_cnt >= period);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         tick_cnt <= 17'h0_0000;
      else if (tick)
         tick_cnt <= 17'h0_0000;
      else
         tick_cnt <= tick_cnt + 17'h0_0001;
   end

   // -------------------------------------------------------------------
   // Output rate divider.
   // -------------------------------------------------------------------
   logic       div_on;
   logic [7:0] div_cnt;
   logic       smp;

   assign div_on = (bypass == 2'b00) && (lp != 3'h0)
                   && (lp != gyrcf_pkg::LP_WIDE);

   // The strobe is registered, so samples are taken one cycle after tick.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         div_cnt <= 8'h00;
         smp     <= 1'b0;
      end
      else if (tick)
      begin
         if (!div_on || div_cnt >= div)
         begin
            div_cnt <= 8'h00;
            smp     <= 1'b1;
         end
         else
         begin
            div_cnt <= div_cnt + 8'h01;
            smp     <= 1'b0;
         end
      end
      else
         smp <= 1'b0;
   end

   // -------------------------------------------------------------------
   // Frame sync capture.
   // -------------------------------------------------------------------
   logic fs_s;
   logic lat;
   logic armed;

   gyrcf_sync2 u_sync
   (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    (frame_sync_i),
      .q_o    (fs_s)
   );

   // A toggle in the strobe cycle wins; after one capture, further toggles are ignored until the next strobe.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lat   <= 1'b0;
         armed <= 1'b1;
      end
      else
      begin
         if (smp)
            armed <= 1'b1;
         if (armed && (fs_s != lat))
         begin
            lat   <= fs_s;
            armed <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Output sample registers.
   // -------------------------------------------------------------------
   logic [15:0] temp_out;
   logic [15:0] x_out;
   logic [15:0] y_out;
   logic [15:0] z_out;
   logic [15:0] z_sum;
   logic [15:0] next_z;

   assign z_sum  = raw_z_i + z_bias;
   assign next_z = {z_sum[15:1],
                    (sync_sel == gyrcf_pkg::SYNC_Z) ? lat : z_sum[0]};

   // Sync select codes 5 to 7 leave every sample untouched.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         temp_out <= 16'h0000;
         x_out    <= 16'h0000;
         y_out    <= 16'h0000;
         z_out    <= 16'h0000;
      end
      else if (smp)
      begin
         temp_out <= {raw_temp_i[15:1], (sync_sel == gyrcf_pkg::SYNC_TEMP)
                      ? lat : raw_temp_i[0]};
         x_out    <= {raw_x_i[15:1], (sync_sel == gyrcf_pkg::SYNC_X)
                      ? lat : raw_x_i[0]};
         y_out    <= {raw_y_i[15:1], (sync_sel == gyrcf_pkg::SYNC_Y)
                      ? lat : raw_y_i[0]};
         z_out    <= next_z;
      end
   end

   // -------------------------------------------------------------------
   // Sample FIFO of corrected Z words.
   // -------------------------------------------------------------------
   localparam int AW = gyrcf_pkg::FIFO_AW;
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0]   count;
   logic          full;
   logic          pop;
   logic          push;
   logic          ovw;
   logic [15:0]   head;

   assign full = (count == (AW+1)'(2**AW));
   assign pop  = rd_i && (addr_i == gyrcf_pkg::ADDR_FDATA_L)
                 && (count != '0);
   assign push = smp && (!full || pop || !fifo_mode);
   assign ovw  = push && full && !pop;
   assign next_rd_ptr = rd_ptr + AW'(pop || ovw);

   // Overwrite moves both pointers and keeps the count at full.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         rd_ptr <= next_rd_ptr;
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (push && !pop && !full)
            count <= count + (AW+1)'(1);
         else if (pop && !push)
            count <= count - (AW+1)'(1);
      end
   end

   // Reading at the next pointer keeps the head word current every cycle except the one after a write into the head slot.
   gyrcf_fifo_mem #(.W(gyrcf_pkg::FIFO_W), .AW(AW)) u_mem
   (
      .clk_i   (clk_i),
      .we_i    (push),
      .waddr_i (wr_ptr),
      .wdata_i (next_z),
      .raddr_i (next_rd_ptr),
      .rdata_o (head)
   );

   // -------------------------------------------------------------------
   // Read port.
   // -------------------------------------------------------------------
   // Unmapped addresses and idle cycles return zero.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (rd_i)
      begin
         unique case (addr_i)
            gyrcf_pkg::ADDR_ZB_HI:   rdata_o <= z_bias[15:8];
            gyrcf_pkg::ADDR_ZB_LO:   rdata_o <= z_bias[7:0];
            gyrcf_pkg::ADDR_DIV:     rdata_o <= div;
            gyrcf_pkg::ADDR_GCFG:    rdata_o <= gcfg;
            gyrcf_pkg::ADDR_RCFG:    rdata_o <= rcfg;
            gyrcf_pkg::ADDR_TEMP_HI: rdata_o <= temp_out[15:8];
            gyrcf_pkg::ADDR_TEMP_LO: rdata_o <= temp_out[7:0];
            gyrcf_pkg::ADDR_X_HI:    rdata_o <= x_out[15:8];
            gyrcf_pkg::ADDR_X_LO:    rdata_o <= x_out[7:0];
            gyrcf_pkg::ADDR_Y_HI:    rdata_o <= y_out[15:8];
            gyrcf_pkg::ADDR_Y_LO:    rdata_o <= y_out[7:0];
            gyrcf_pkg::ADDR_Z_HI:    rdata_o <= z_out[15:8];
            gyrcf_pkg::ADDR_Z_LO:    rdata_o <= z_out[7:0];
            gyrcf_pkg::ADDR_FCOUNT:  rdata_o <= 8'(count);
            gyrcf_pkg::ADDR_FDATA_H: rdata_o <= head[15:8];
            gyrcf_pkg::ADDR_FDATA_L: rdata_o <= head[7:0];
            default:                 rdata_o <= 8'h00;
         endcase
      end
      else
         rdata_o <= 8'h00;
   end

   // -------------------------------------------------------------------
   // Filter and range status outputs.
   // -------------------------------------------------------------------
   // Bypass bit 0 dominates; the lowpass setting only counts with 00.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rate_khz_o  <= 6'h00;
         rate_bw_o   <= 14'h0000;
         temp_bw_o   <= 12'h000;
         fs_dps_o    <= 11'h000;
         full_scale_select_o    <= 2'b00;
         self_test_o <= 3'b000;
         sample_o    <= 1'b0;
         fifo_full_o <= 1'b0;
      end
      else
      begin
         if (bypass[0])
         begin
            rate_khz_o <= gyrcf_pkg::KHZ_32;
            rate_bw_o  <= gyrcf_pkg::RATE_BW_BYP0;
            temp_bw_o  <= gyrcf_pkg::TEMP_BW_BYP;
         end
         else if (bypass[1])
         begin
            rate_khz_o <= gyrcf_pkg::KHZ_32;
            rate_bw_o  <= gyrcf_pkg::RATE_BW_BYP1;
            temp_bw_o  <= gyrcf_pkg::TEMP_BW_BYP;
         end
         else
         begin
            rate_khz_o <= lp_fast ? gyrcf_pkg::KHZ_8
                                  : gyrcf_pkg::KHZ_1;
            rate_bw_o  <= gyrcf_pkg::RATE_BW_HZ[lp];
            temp_bw_o  <= gyrcf_pkg::TEMP_BW_HZ[lp];
         end
         fs_dps_o    <= gyrcf_pkg::FS_DPS[fs];
         full_scale_select_o    <= fs;
         self_test_o <= rcfg[gyrcf_pkg::ST_LSB +: 3];
         sample_o    <= smp;
         fifo_full_o <= full;
      end
   end

   // -------------------------------------------------------------------
   // Assertions.
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_sync_toggle;
      armed && (fs_s != lat);
   endsequence

   sequence s_sync_locked;
      !armed && !smp;
   endsequence

   bias_write_a: assert property (
      wr_i && addr_i == gyrcf_pkg::ADDR_ZB_LO |=> z_bias[7:0] == $past(wdata_i))
      else $error("Z bias low byte not stored.");
   bias_add_a: assert property (
      smp |=> z_out[15:1] == $past(raw_z_i[15:1] + z_bias[15:1]
                                   + 15'(raw_z_i[0] & z_bias[0])))
      else $error("Z output is not raw plus bias.");
   div_hold_a: assert property (
      tick && div_on && div_cnt < div |=> !smp)
      else $error("Sample strobe came before the divider expired.");
   div_skip_a: assert property (
      tick && !div_on |=> smp)
      else $error("Divider was applied while it should be ignored.");
   fifo_keep_a: assert property (
      smp && full && fifo_mode && !pop |=> wr_ptr == $past(wr_ptr) && full)
      else $error("Write into a full FIFO was not dropped.");
   fifo_over_a: assert property (
      smp && full && !fifo_mode && !pop
      |=> full && rd_ptr == $past(rd_ptr) + AW'(1))
      else $error("Full FIFO did not overwrite the oldest word.");
   sync_place_a: assert property (
      smp && sync_sel == gyrcf_pkg::SYNC_X |=> x_out[0] == $past(lat))
      else $error("Sync bit missing from X low byte.");
   sync_once_a: assert property (
      s_sync_toggle ##1 s_sync_locked |=> lat == $past(lat))
      else $error("Latched sync toggled twice before a strobe.");
   byp_bw_a: assert property (
      bypass[0] |=> rate_bw_o == gyrcf_pkg::RATE_BW_BYP0
                    && rate_khz_o == gyrcf_pkg::KHZ_32)
      else $error("Bypass 0 bandwidth or rate wrong.");
   lp_rate_a: assert property (
      bypass == 2'b00 && lp == 3'h3 |=> rate_khz_o == gyrcf_pkg::KHZ_1)
      else $error("Lowpass setting 3 not at 1 kHz.");
   fs_range_a: assert property (
      fs == 2'b11 |=> fs_dps_o == gyrcf_pkg::FS_DPS[3])
      else $error("Full scale 11 not 2000 dps.");

endmodule

/* dv/tb_gyro_rate_filter_config.sv */
`timescale 1ns/1ns
module tb_gyro_rate_filter_config;
   // ----------
   // Signals.
   // ----------
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [7:0]  rdata_o;
   logic [15:0] raw_temp_i = 16'h0a0a;
   logic [15:0] raw_x_i = 16'h1b1a;
   logic [15:0] raw_y_i = 16'h2c2c;
   logic [15:0] raw_z_i = 16'h1234;
   logic        frame_sync_i = 1'b0;
   logic        sample_o;
   logic [5:0]  rate_khz_o;
   logic [13:0] rate_bw_o;
   logic [11:0] temp_bw_o;
   logic [10:0] fs_dps_o;
   logic [1:0]  full_scale_select_o;
   logic [2:0]  self_test_o;
   logic        fifo_full_o;
   logic        ramp = 1'b0;
   logic        lvl;
   logic [7:0]  d;
   logic [15:0] base;
   logic [15:0] w [16];
   int          k;
   int          n_fail = 0;
   int          checks = 0;
   // Expected filter and range tables, indexed by lowpass setting or range.
   logic [5:0]  t_khz [8] = '{6'h08, 6'h01, 6'h01, 6'h01,
                              6'h01, 6'h01, 6'h01, 6'h08};
   logic [13:0] t_rbw [8] = '{14'h00fa, 14'h00b0, 14'h005c, 14'h0029,
                              14'h0014, 14'h000a, 14'h0005, 14'h0cd1};
   logic [11:0] t_tbw [8] = '{12'hfa0, 12'h0bc, 12'h062, 12'h02a,
                              12'h014, 12'h00a, 12'h005, 12'hfa0};
   logic [10:0] t_fs [4] = '{11'h0fa, 11'h1f4, 11'h3e8, 11'h7d0};
   // Divider cases: config, rate config, divider, cycles between strobes.
   logic [7:0]  p_g [5] = '{8'h01, 8'h00, 8'h07, 8'h01, 8'h06};
   logic [7:0]  p_r [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
   logic [7:0]  p_d [5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h00};
   int          p_e [5] = '{159, 19, 19, 3124, 39};

   // Short counts keep the 1 kHz and 8 kHz periods at 40 and 20 cycles.
   gyrcf_top #(.CYC_1K(40), .CYC_8K(20)) uut (.clk_i, .rstn_i, .addr_i,
      .wdata_i, .wr_i, .rd_i, .rdata_o, .raw_temp_i, .raw_x_i, .raw_y_i,
      .raw_z_i, .frame_sync_i, .sample_o, .rate_khz_o, .rate_bw_o,
      .temp_bw_o, .fs_dps_o, .full_scale_select_o, .self_test_o, .fifo_full_o);

   // Clock at 100 MHz.
   always #5 clk_i = ~clk_i;

   // Ramp the Z sample so every stored word is distinct and ordered.
   always @(posedge clk_i)
      if (ramp && sample_o)
         raw_z_i <= raw_z_i + 16'h0001;

   // ----------
   // Tasks.
   // ----------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rst;
      rstn_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Waits for the next sample strobe; n is the idle cycles before it.
   task automatic ws(output int n);
      n = 0;
      @(posedge clk_i);
      while (sample_o !== 1'b1 && n < 20000)
      begin
         n++;
         @(posedge clk_i);
      end
      if (n == 20000)
         n_fail++;
   endtask

   task automatic cfg(input logic [5:0] kz, input logic [13:0] r,
                      input logic [11:0] t);
      repeat (2) @(posedge clk_i);
      #1;
      chk("rate_khz", 16'(kz), 16'(rate_khz_o));
      chk("rate_bw", 16'(r), 16'(rate_bw_o));
      chk("temp_bw", 16'(t), 16'(temp_bw_o));
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------
   // Tests.
   // ----------
   initial
   begin
      rst();
      for (int i = 0; i < 5; i++)
      begin
         rd(8'h17 + 8'(i));
         chk("reset value", 16'h0000, 16'(d));
      end
      cfg(6'h08, 14'h00fa, 12'hfa0);
      $display("test reset done");
      // Reserved bits are written as zero; every other bit is kept.
      wr(8'h1a, 8'h7f);
      rd(8'h1a);
      chk("gen config", 16'h007f, 16'(d));
      wr(8'h1b, 8'hfb);
      rd(8'h1b);
      chk("rate config", 16'h00fb, 16'(d));
      cfg(6'h20, 14'h1fed, 12'hfa0);
      wr(8'h17, 8'hff);
      wr(8'h18, 8'hf0);
      rd(8'h17);
      chk("bias high", 16'h00ff, 16'(d));
      rd(8'h18);
      chk("bias low", 16'h00f0, 16'(d));
      rd(8'h20);
      chk("unmapped", 16'h0000, 16'(d));
      $display("test registers done");
      wr(8'h1b, 8'h02);
      wr(8'h1a, 8'h03);
      cfg(6'h20, 14'h0cd1, 12'hfa0);
      wr(8'h1b, 8'h01);
      cfg(6'h20, 14'h1fed, 12'hfa0);
      wr(8'h1b, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h1a, 8'(i));
         cfg(t_khz[i], t_rbw[i], t_tbw[i]);
      end
      for (int f = 0; f < 4; f++)
      begin
         wr(8'h1b, {3'(f + 3), 2'(f), 3'b000});
         cfg(6'h08, 14'h0cd1, 12'hfa0);
         chk("fs_dps", 16'(t_fs[f]), 16'(fs_dps_o));
         chk("full_scale_select", 16'(f), 16'(full_scale_select_o));
         chk("self_test", 16'(f + 3), 16'(self_test_o));
      end
      $display("test filter and range done");
      wr(8'h1b, 8'h00);
      wr(8'h1a, 8'h00);
      ws(k);
      ws(k);
      rd(8'h47);
      w[0][15:8] = d;
      rd(8'h48);
      w[0][7:0] = d;
      chk("z corrected", 16'h1224, w[0]);
      rd(8'h44);
      chk("x low raw", 16'h001a, 16'(d));
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h19, p_d[i]);
         wr(8'h1b, p_r[i]);
         wr(8'h1a, p_g[i]);
         ws(k);
         ws(k);
         chk("strobe gap", 16'(p_e[i]), 16'(k));
      end
      $display("test divider done");
      wr(8'h1b, 8'h00);
      // The latch holds the pin's first toggle until the next strobe, so a pulse shows in one sample only.
      lvl = 1'b1;
      for (int s = 1; s < 5; s++)
      begin
         wr(8'h1a, 8'(s * 8));
         ws(k);
         frame_sync_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         frame_sync_i <= 1'b0;
         ws(k);
         for (int j = 0; j < 4; j++)
         begin
            rd(8'h42 + 8'(2 * j));
            chk("sync bit", 16'(j == s - 1 ? lvl : 1'b0), 16'(d[0]));
         end
         ws(k);
         rd(8'h40 + 8'(2 * s));
         chk("sync clear", 16'h0000, 16'(d[0]));
      end
      $display("test sync done");
      // A second reset empties the FIFO before each overflow mode.
      for (int m = 1; m >= 0; m--)
      begin
         rst();
         base = raw_z_i;
         wr(8'h1a, 8'(m * 64));
         ramp <= 1'b1;
         for (int i = 0; i < 40 && fifo_full_o !== 1'b1; i++)
            ws(k);
         chk("fifo full", 16'h0001, 16'(fifo_full_o));
         repeat (5) ws(k);
         wr(8'h19, 8'hff);
         wr(8'h1a, 8'(m * 64 + 1));
         rd(8'h72);
         chk("fifo count", 16'h0010, 16'(d));
         for (int i = 0; i < 16; i++)
         begin
            rd(8'h73);
            w[i][15:8] = d;
            rd(8'h74);
            w[i][7:0] = d;
         end
         for (int i = 1; i < 16; i++)
            chk("fifo order", w[i - 1] + 16'h0001, w[i]);
         chk("fifo end", m ? base : raw_z_i - 16'h0001,
             m ? w[0] : w[15]);
         ramp <= 1'b0;
      end
      $display("test fifo done");
      summarize();
   end

   // Watchdog at twice the expected run of under ten thousand cycles.
   initial
   begin
      #200_000;
      n_fail++;
      summarize();
   end
endmodule
